/* hdl/mac_accum_pkg.sv */
package mac_accum_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ACC0_OFS = 8'h08;
  localparam logic [7:0] ACC4_OFS = 8'h18;
  localparam logic [7:0] EVT_OFS = 8'h1c;
  localparam logic [7:0] MASK_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int ACC_W = 40;
  localparam int SHIFT_W = 3;
  localparam int LSHIFT_LSB = 0;
  localparam int RSHIFT_LSB = 3;
  localparam int FILL_BIT = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SWAP_CMD = 8'h80;
  localparam logic [2:0] TOP_BYTE = 3'h4;
  localparam int COMP_LSB = 0;
  localparam int HOST_LSB = 2;

  // Bank status codes as seen in the status register.
  localparam logic [1:0] BANK_EMPTY = 2'h0;
  localparam logic [1:0] BANK_READY = 2'h1;
  localparam logic [1:0] BANK_BUSY = 2'h2;
  localparam logic [1:0] BANK_DONE = 2'h3;

  // Event bits, shared by the event and mask registers.
  localparam int EVT_W = 3;
  localparam int EVT_COMPUTE_BANK = 0;
  localparam int EVT_SWAP = 1;
  localparam int EVT_DROP = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wbReq_s;

  typedef struct packed {
    logic [ACC_W-1:0] hostAcc;
    logic [7:0] ctl;
    logic [1:0] hostStat;
    logic [1:0] compStat;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic ack;
    logic [31:0] datOut;
    logic swap;
  } macState_s;

  // True when the address selects one of the accumulator bytes.
  function automatic logic isAccAdr(logic [7:0] adr);
    return adr >= ACC0_OFS && adr <= ACC4_OFS && adr[1:0] == 2'h0;
  endfunction

  // Byte number of an accumulator address.
  function automatic logic [2:0] accIdx(logic [7:0] adr);
    logic [7:0] diff;
    diff = adr - ACC0_OFS;
    return diff[4:2];
  endfunction

endpackage

/* hdl/acc_shift_unit.sv */
`timescale 1ns/1ps
module acc_shift_unit
  import mac_accum_pkg::*;
(
  input wire logic [ACC_W-1:0] acc, // Stored host-bank accumulator.
  input wire logic [2:0] byteIdx, // Accumulator byte addressed.
  input wire logic [SHIFT_W-1:0] loadShift, // Left shift on writes.
  input wire logic [SHIFT_W-1:0] readShift, // Right shift on reads.
  input wire logic fillBit, // Value for vacated low bits.
  input wire logic [7:0] wrByte, // Byte being written.
  output logic [ACC_W-1:0] loadedAcc, // Accumulator after the write.
  output logic [7:0] readByte // Shifted byte for a read.
);

  // ----------------------------------------------------------------
  // Shifted load and sign-extended readout
  // ----------------------------------------------------------------
  // The byte lands at 8k+s; bits past the top are lost in the cut.
  always_comb begin
    logic [5:0] pos;
    logic [47:0] val;
    logic [47:0] mask;
    logic [47:0] low;
    logic [47:0] ext;
    pos = {byteIdx, 3'h0} + 6'(loadShift);
    val = 48'(wrByte) << pos;
    mask = 48'hff << pos;
    low = ~(48'hffff_ffff_ffff << loadShift);
    if (byteIdx == 3'h0) begin
      mask = mask | low;
      if (fillBit) begin
        val = val | low;
      end
    end
    loadedAcc = (acc & ~mask[ACC_W-1:0]) | (val[ACC_W-1:0] & mask[ACC_W-1:0]);
    ext = {{8{acc[ACC_W-1]}}, acc};
    ext = 48'($signed(ext) >>> readShift);
    readByte = ext[{byteIdx, 3'h0} +: 8];
  end

endmodule // acc_shift_unit

/* hdl/mac_accumulator_bank.sv */
`timescale 1ns/1ps
module mac_accumulator_bank
  import mac_accum_pkg::*;
(
  input wire logic core_clk, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire wbReq_s wbReq, // Wishbone request from the host.
  output logic [31:0] wbDat, // Wishbone read data.
  output logic wbAck, // Wishbone acknowledge.
  input wire logic blockInputEnd, // Access is last of a block input.
  input wire logic calcDefined, // A new calculation was defined.
  input wire logic calcDone, // Running calculation has finished.
  input wire logic [ACC_W-1:0] computeAcc, // Compute bank accumulator.
  output logic [ACC_W-1:0] hostAcc, // Host bank accumulator.
  output logic [1:0] hostStatus, // Host bank status code.
  output logic [1:0] computeStatus, // Compute bank status code.
  output logic bankSwap, // One-cycle pulse on a bank swap.
  output logic irq // Level interrupt, unmasked event pending.
);

  // ----------------------------------------------------------------
  // State and reset value
  // ----------------------------------------------------------------
  localparam macState_s STATE_RST = '{
    hostAcc: '0,
    ctl: CTRL_RST,
    hostStat: BANK_EMPTY,
    compStat: BANK_EMPTY,
    evt: EVT_RST,
    mask: EVT_RST,
    ack: 1'b0,
    datOut: 32'h0,
    swap: 1'b0
  };

  macState_s r;
  macState_s next_r;
  logic taken;
  logic accHit;
  logic [2:0] byteIdx;
  logic [ACC_W-1:0] loadedAcc;
  logic [7:0] readByte;

  // A request is taken once; ack drops in the cycle after it is given.
  assign taken = wbReq.cyc && wbReq.stb && !r.ack;
  assign accHit = isAccAdr(wbReq.adr);
  assign byteIdx = accIdx(wbReq.adr);

  // Shifting datapath for accumulator byte loads and reads.
  acc_shift_unit shifter (
    .acc(r.hostAcc),
    .byteIdx(byteIdx),
    .loadShift(r.ctl[LSHIFT_LSB +: SHIFT_W]),
    .readShift(r.ctl[RSHIFT_LSB +: SHIFT_W]),
    .fillBit(r.ctl[FILL_BIT]),
    .wrByte(wbReq.dat[7:0]),
    .loadedAcc(loadedAcc),
    .readByte(readByte)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Host accesses act first, then calculation events; events are set
  // after an event-register read clears them so a set always wins.
  always_comb begin
    logic [EVT_W-1:0] setEvt;
    next_r = r;
    setEvt = '0;
    next_r.ack = 1'b0;
    next_r.swap = 1'b0;
    if (taken) begin
      next_r.ack = 1'b1;
      next_r.datOut = 32'h0;
      if (wbReq.we) begin
        if (wbReq.sel[0]) begin
          if (wbReq.adr == CTRL_OFS) begin
            next_r.ctl = wbReq.dat[7:0];
          end else if (accHit) begin
            next_r.hostAcc = loadedAcc;
          end else if (wbReq.adr == MASK_OFS) begin
            next_r.mask = wbReq.dat[EVT_W-1:0];
          end else if (wbReq.adr == STAT_OFS &&
                       wbReq.dat[7:0] == SWAP_CMD &&
                       r.hostStat == BANK_EMPTY &&
                       r.compStat == BANK_DONE) begin
            next_r.hostAcc = computeAcc;
            next_r.hostStat = BANK_DONE;
            next_r.compStat = BANK_EMPTY;
            next_r.swap = 1'b1;
          end
          // Writing a unit register discards a pending result.
          if ((wbReq.adr == CTRL_OFS || accHit) &&
              r.hostStat == BANK_DONE) begin
            next_r.hostStat = BANK_EMPTY;
            setEvt[EVT_DROP] = 1'b1;
          end
        end
      end else begin
        if (wbReq.adr == CTRL_OFS) begin
          next_r.datOut = {24'h0, r.ctl};
        end else if (wbReq.adr == STAT_OFS) begin
          next_r.datOut = 32'({r.hostStat, r.compStat});
        end else if (accHit) begin
          next_r.datOut = {24'h0, readByte};
          if (r.hostStat == BANK_DONE &&
              (blockInputEnd || byteIdx == TOP_BYTE)) begin
            next_r.hostStat = BANK_EMPTY;
          end
        end else if (wbReq.adr == EVT_OFS) begin
          next_r.datOut = 32'(r.evt);
          next_r.evt = '0;
        end else if (wbReq.adr == MASK_OFS) begin
          next_r.datOut = 32'(r.mask);
        end
      end
    end
    // Completion of the running calculation.
    if (calcDone && next_r.compStat == BANK_BUSY) begin
      setEvt[EVT_COMPUTE_BANK] = 1'b1;
      if (next_r.hostStat == BANK_READY) begin
        next_r.hostAcc = computeAcc;
        next_r.hostStat = BANK_DONE;
        next_r.swap = 1'b1;
      end else begin
        next_r.compStat = BANK_DONE;
      end
    end
    // A newly defined calculation enters through an empty host bank.
    if (calcDefined && next_r.hostStat == BANK_EMPTY) begin
      if (next_r.compStat == BANK_BUSY) begin
        next_r.hostStat = BANK_READY;
      end else begin
        if (next_r.compStat == BANK_DONE) begin
          next_r.hostAcc = computeAcc;
          next_r.hostStat = BANK_DONE;
        end
        next_r.compStat = BANK_BUSY;
        next_r.swap = 1'b1;
      end
    end
    if (next_r.swap) begin
      setEvt[EVT_SWAP] = 1'b1;
    end
    next_r.evt = next_r.evt | setEvt;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable low holds every field, including the bus answer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= STATE_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wbDat = r.datOut;
  assign wbAck = r.ack;
  assign hostAcc = r.hostAcc;
  assign hostStatus = r.hostStat;
  assign computeStatus = r.compStat;
  assign bankSwap = r.swap;
  assign irq = |(r.evt & r.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic accRead;
  logic accWrite;
  assign accRead = ce && taken && !wbReq.we && accHit;
  assign accWrite = ce && taken && wbReq.we && wbReq.sel[0] && accHit;

  // Bit positions and low fill mask seen by the checks below.
  logic [5:0] loadPos;
  logic [5:0] readPos;
  logic [7:0] fillMask;
  assign loadPos = {byteIdx, 3'h0} + 6'(r.ctl[LSHIFT_LSB +: SHIFT_W]);
  assign readPos = {byteIdx, 3'h0} + 6'(r.ctl[RSHIFT_LSB +: SHIFT_W]);
  assign fillMask = ~(8'hff << r.ctl[LSHIFT_LSB +: SHIFT_W]);

  // Reading the top byte of a finished result empties the host bank.
  property p_top_read_empties;
    accRead && byteIdx == TOP_BYTE && r.hostStat == BANK_DONE
      |=> hostStatus == BANK_EMPTY;
  endproperty
  a_top_read_empties: assert property (p_top_read_empties)
    else $error("top byte read did not empty host bank");

  // The last read of a block input empties the host bank.
  property p_block_end_empties;
    accRead && blockInputEnd && r.hostStat == BANK_DONE
      |=> hostStatus == BANK_EMPTY && $stable(computeStatus);
  endproperty
  a_block_end_empties: assert property (p_block_end_empties)
    else $error("block input end did not empty host bank");

  // A control write throws away a pending result.
  property p_write_discards;
    ce && taken && wbReq.we && wbReq.sel[0] && wbReq.adr == CTRL_OFS &&
      r.hostStat == BANK_DONE |=> hostStatus == BANK_EMPTY && r.evt[EVT_DROP];
  endproperty
  a_write_discards: assert property (p_write_discards)
    else $error("write did not discard pending result");

  // Completion with the host bank full marks compute done, no swap.
  property p_done_no_swap;
    ce && !taken && calcDone && r.hostStat == BANK_DONE &&
      r.compStat == BANK_BUSY
      |=> computeStatus == BANK_DONE && hostStatus == BANK_DONE && !bankSwap;
  endproperty
  a_done_no_swap: assert property (p_done_no_swap)
    else $error("completion with full host bank misbehaved");

  // The swap command moves the finished result to the host bank.
  property p_swap_cmd;
    ce && taken && wbReq.we && wbReq.sel[0] && wbReq.adr == STAT_OFS &&
      wbReq.dat[7:0] == SWAP_CMD && r.hostStat == BANK_EMPTY &&
      r.compStat == BANK_DONE && !calcDefined
      |=> hostStatus == BANK_DONE && computeStatus == BANK_EMPTY &&
          bankSwap && hostAcc == $past(computeAcc);
  endproperty
  a_swap_cmd: assert property (p_swap_cmd)
    else $error("swap command did not swap banks");

  // Completion with a ready host bank swaps and keeps computing.
  property p_auto_swap;
    ce && calcDone && r.hostStat == BANK_READY && r.compStat == BANK_BUSY
      |=> hostStatus == BANK_DONE && computeStatus == BANK_BUSY && bankSwap
          ##1 !bankSwap;
  endproperty
  a_auto_swap: assert property (p_auto_swap)
    else $error("automatic swap missing or too long");

  // An unshifted write to byte two lands in bits 23:16.
  property p_plain_load;
    accWrite && byteIdx == 3'h2 && r.ctl[LSHIFT_LSB +: SHIFT_W] == 3'h0 &&
      !(calcDone && r.hostStat == BANK_READY)
      |=> hostAcc[23:16] == $past(wbReq.dat[7:0]);
  endproperty
  a_plain_load: assert property (p_plain_load)
    else $error("unshifted byte load misplaced");

  // A seven-bit readout shift of the top byte gives sign copies.
  property p_sign_fill;
    accRead && byteIdx == TOP_BYTE && r.ctl[RSHIFT_LSB +: SHIFT_W] == 3'h7
      |=> wbDat[7:1] == {7{$past(r.hostAcc[ACC_W-1])}} && wbAck;
  endproperty
  a_sign_fill: assert property (p_sign_fill)
    else $error("readout sign fill wrong");

  // Reads never disturb the stored accumulator.
  property p_read_keeps;
    accRead && !calcDone && !calcDefined |=> $stable(hostAcc);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read altered accumulator");

  // The compute bank never shows the ready code.
  property p_comp_codes;
    computeStatus != BANK_READY;
  endproperty
  a_comp_codes: assert property (p_comp_codes)
    else $error("compute bank showed ready code");

  // Reset leaves both banks empty and all settings cleared.
  property p_reset_state;
    @(posedge core_clk) $fell(rst) |-> hostStatus == BANK_EMPTY &&
      computeStatus == BANK_EMPTY && hostAcc == '0 && r.ctl == CTRL_RST;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");

  // The acknowledge stands for one cycle only.
  property p_ack_pulse;
    ce && wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge held too long");

  // A taken request is answered in the next cycle.
  property p_ack_follows;
    ce && taken |=> wbAck;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("request not acknowledged");

  // Reading the event register clears it when nothing new arrives.
  property p_evt_clear;
    ce && taken && !wbReq.we && wbReq.adr == EVT_OFS && !calcDone &&
      !calcDefined |=> r.evt == EVT_RST;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event read did not clear events");

  // Bits vacated below byte zero take the fill bit.
  property p_fill_load;
    accWrite && byteIdx == 3'h0 && !calcDone && !calcDefined
      |=> (hostAcc[7:0] & $past(fillMask)) ==
          ($past(r.ctl[FILL_BIT]) ? $past(fillMask) : 8'h00);
  endproperty
  a_fill_load: assert property (p_fill_load)
    else $error("load fill bits wrong");

  // Middle bytes land whole at 8k plus the load shift.
  property p_load_byte;
    accWrite && byteIdx inside {3'h1, 3'h2, 3'h3} &&
      !calcDone && !calcDefined
      |=> ((hostAcc >> $past(loadPos)) & 40'hff) ==
          40'($past(wbReq.dat[7:0]));
  endproperty
  a_load_byte: assert property (p_load_byte)
    else $error("shifted byte load misplaced");

  // Lower bytes read back from bit 8k plus the readout shift.
  property p_read_byte;
    accRead && byteIdx != TOP_BYTE
      |=> ($past((r.hostAcc >> readPos) & 40'hff) == 40'(wbDat[7:0])) &&
          wbDat[31:8] == 24'h0;
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("shifted byte readout wrong");

  c_auto_swap: cover property (ce && calcDone && r.hostStat == BANK_READY);
  c_top_read: cover property (accRead && byteIdx == TOP_BYTE &&
                              r.hostStat == BANK_DONE);
  c_shift_load: cover property (accWrite && r.ctl[FILL_BIT] &&
                                r.ctl[LSHIFT_LSB +: SHIFT_W] == 3'h3);
  c_irq: cover property (irq);

endmodule // mac_accumulator_bank

/* tb/compute_bank_datapath_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Stand-in for the multiply datapath behind the compute bank
// ------------------------------------------------------------------
module compute_bank_datapath_model (
  input wire logic core_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic go, // Start a calculation.
  input wire logic [3:0] delay, // Extra cycles before finishing.
  input wire logic [39:0] result, // Value the calculation ends with.
  output logic calcDone, // One-cycle finish pulse.
  output logic [39:0] computeAcc // Compute bank accumulator.
);
  logic busy;
  logic [3:0] cnt;

  // Counts down the chosen delay, so answers come promptly or slowly.
  always_ff @(posedge core_clk) begin
    calcDone <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      computeAcc <= 40'h0;
    end else if (go) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      calcDone <= 1'b1;
      computeAcc <= result;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // compute_bank_datapath_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import mac_accum_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  wbReq_s wbReq = '0;
  logic blockInputEnd = 1'b0;
  logic calcDefined = 1'b0;
  logic go = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [39:0] result = 40'h0;
  logic calcDone, wbAck, bankSwap, irq;
  logic [ACC_W-1:0] computeAcc, hostAcc;
  logic [31:0] wbDat;
  logic [1:0] hostStatus, computeStatus;
  logic [7:0] rd;
  logic [2:0] s;
  logic [39:0] v;
  logic signed [39:0] sv;
  int errCount = 0;
  int checksDone = 0;
  int cycles = 0;
  int swaps = 0;

  // ----------------------------------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------------------------------
  always #50 core_clk = ~core_clk;

  // Cuts a hang short well beyond the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (bankSwap === 1'b1) begin
      swaps++;
    end
    if (cycles == 3000) begin
      errCount++;
      wrap_up();
    end
  end

  mac_accumulator_bank i_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .wbReq(wbReq), .wbDat(wbDat), .wbAck(wbAck),
    .blockInputEnd(blockInputEnd), .calcDefined(calcDefined),
    .calcDone(calcDone), .computeAcc(computeAcc), .hostAcc(hostAcc),
    .hostStatus(hostStatus), .computeStatus(computeStatus),
    .bankSwap(bankSwap), .irq(irq));

  compute_bank_datapath_model i_dp (.core_clk(core_clk), .rst(rst), .go(go),
    .delay(delay), .result(result), .calcDone(calcDone),
    .computeAcc(computeAcc));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] got, exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // One classic Wishbone cycle; holds the request until ack is seen.
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [7:0] wd, input logic bie);
    int n;
    n = 0;
    wbReq <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, wd}};
    blockInputEnd <= bie;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDat[7:0];
    wbReq <= '0;
    blockInputEnd <= 1'b0;
    if (n >= 20) begin
      chk(40'h0, 40'h1, "no ack");
    end
    @(posedge core_clk);
  endtask

  task automatic stat(input logic [1:0] h, c, input string msg);
    chk(40'(hostStatus), 40'(h), msg);
    chk(40'(computeStatus), 40'(c), msg);
    xfer(1'b0, STAT_OFS, 8'h00, 1'b0);
    chk(40'(rd), 40'({4'h0, h, c}), msg);
  endtask

  // Five byte writes, low byte first.
  task automatic loadAcc(input logic [39:0] a);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, ACC0_OFS + 8'(4 * k), a[8 * k +: 8], 1'b0);
    end
  endtask

  task automatic defineCalc();
    calcDefined <= 1'b1;
    @(posedge core_clk);
    calcDefined <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic compute_bank(input logic [39:0] r, input logic [3:0] d);
    int n;
    n = 0;
    result <= r;
    delay <= d;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (calcDone !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40) begin
      chk(40'h0, 40'h1, "no finish");
    end
    @(posedge core_clk);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    stat(BANK_EMPTY, BANK_EMPTY, "reset status");
    chk(hostAcc, 40'h0, "reset acc");
    xfer(1'b0, CTRL_OFS, 8'h00, 1'b0);
    chk(40'(rd), 40'(CTRL_RST), "reset control");
    xfer(1'b0, 8'h3c, 8'h00, 1'b0);
    chk(40'(rd), 40'h0, "unmapped read");
    // A calculation defined while the clock enable is low is ignored.
    ce <= 1'b0;
    defineCalc();
    ce <= 1'b1;
    stat(BANK_EMPTY, BANK_EMPTY, "frozen by clock enable");
    xfer(1'b1, MASK_OFS, 8'h07, 1'b0);
    xfer(1'b0, MASK_OFS, 8'h00, 1'b0);
    chk(40'(rd), 40'h7, "mask readback");
    // Load shifts 0, 3, 6 and 1 with the fill bit alternating.
    for (int i = 0; i < 4; i++) begin
      s = 3'(i * 3);
      xfer(1'b1, CTRL_OFS, {1'b0, i[0], 3'h0, s}, 1'b0);
      loadAcc(40'hc3a55a96e1);
      v = (40'hc3a55a96e1 << s) | (i[0] ? (40'h1 << s) - 40'h1 : 40'h0);
      chk(hostAcc, v, "load shift");
    end
    // Every readout shift on a negative accumulator.
    xfer(1'b1, CTRL_OFS, 8'h00, 1'b0);
    loadAcc(40'h9a5c3e71b4);
    sv = 40'h9a5c3e71b4;
    for (int j = 0; j < 8; j++) begin
      xfer(1'b1, CTRL_OFS, {2'h0, 3'(j), 3'h0}, 1'b0);
      for (int k = 0; k < 5; k++) begin
        xfer(1'b0, ACC0_OFS + 8'(4 * k), 8'h00, 1'b0);
        v = sv >>> (8 * k + j);
        chk(40'(rd), 40'(v[7:0]), "readout");
      end
    end
    chk(hostAcc, 40'h9a5c3e71b4, "acc kept");
    // Bank progression.
    defineCalc();
    stat(BANK_EMPTY, BANK_BUSY, "compute_bank start");
    compute_bank(40'h1122334455, 4'h5);
    stat(BANK_EMPTY, BANK_DONE, "compute_bank done");
    chk(40'(irq), 40'h1, "irq raised");
    xfer(1'b0, EVT_OFS, 8'h00, 1'b0);
    chk(40'(rd[EVT_COMPUTE_BANK]), 40'h1, "compute_bank event");
    chk(40'(irq), 40'h0, "irq cleared");
    xfer(1'b1, STAT_OFS, SWAP_CMD, 1'b0);
    stat(BANK_DONE, BANK_EMPTY, "manual swap");
    chk(hostAcc, 40'h1122334455, "swapped acc");
    xfer(1'b0, ACC4_OFS, 8'h00, 1'b0);
    stat(BANK_EMPTY, BANK_EMPTY, "top byte read");
    xfer(1'b1, MASK_OFS, 8'h00, 1'b0);
    defineCalc();
    defineCalc();
    stat(BANK_READY, BANK_BUSY, "queued compute_bank");
    compute_bank(40'h0a0b0c0d0e, 4'h0);
    stat(BANK_DONE, BANK_BUSY, "auto swap");
    chk(hostAcc, 40'h0a0b0c0d0e, "auto swap acc");
    chk(40'(irq), 40'h0, "masked irq");
    compute_bank(40'h7f00ff00ff, 4'h9);
    stat(BANK_DONE, BANK_DONE, "done no swap");
    chk(hostAcc, 40'h0a0b0c0d0e, "no swap acc");
    xfer(1'b0, ACC0_OFS + 8'h04, 8'h00, 1'b1);
    stat(BANK_EMPTY, BANK_DONE, "block input end");
    xfer(1'b1, STAT_OFS, SWAP_CMD, 1'b0);
    xfer(1'b1, MASK_OFS, 8'(3'h1 << EVT_DROP), 1'b0);
    chk(40'(irq), 40'h0, "drop masked only");
    xfer(1'b1, CTRL_OFS, 8'h00, 1'b0);
    stat(BANK_EMPTY, BANK_EMPTY, "write discards");
    chk(40'(irq), 40'h1, "discard irq");
    chk(40'(swaps), 40'h5, "swap pulses");
    wrap_up();
  end
endmodule // tb
